/* File: include/cmd_line_defs.vh */
`ifndef CMD_LINE_DEFS_VH
`define CMD_LINE_DEFS_VH

// Decoded command codes from the line parser
`define CMD_MEM_ACCESS 4'h1
`define CMD_BOOT_JUMP 4'h2
`define CMD_SHADOW_REPLAY 4'h3
`define CMD_PROFILE_SAVE 4'h4
`define CMD_PROFILE_RELOAD 4'h5
`define CMD_RECEIVER_OFF 4'h6
`define CMD_ASSOCIATE 4'h7
`define CMD_NETWORK_SCAN 4'h8
`define CMD_REG_WRITE 4'h9
`define CMD_REG_READ 4'hA

// Memory-access arguments
`define MEM_EE_DUMP_APP 8'h01
`define MEM_EE_DUMP_ALL 8'h02
`define MEM_EE_LINE_WR 8'h03
`define MEM_FL_READ 8'h04
`define MEM_FL_WRITE 8'h05
`define MEM_FL_SECT_ERASE 8'h06
`define MEM_FL_FULL_ERASE 8'h07
`define MEM_BLOCK_SIZE 8'h40

// Register numbers and fields
`define REG_RECOVERY 8'h0B
`define REG_TIMER_A 8'h11
`define REG_TIMER_B 8'h12
`define REG_UNLOCK 8'h5E
`define UNLOCK_BOOT_BIT 5
`define REC_WDT_LSB 0
`define REC_WDT_MSB 2
`define REC_MAC_LSB 4
`define REC_MAC_MSB 7
`define REC_WDT_MAX 4'h7
`define REC_MAC_MAX 4'hF
`define REG_RESET_VAL 8'h00

// Timing
`define CLK_HZ 20000000
`define REPLAY_TICKS_PER_S 16
`define WDT_DEFAULT_MS 2000
`define WDT_ASSOC_MS 8000
`define BOOT_WAIT_MS 20000
`define FULL_ERASE_MS 6000
`define MS_TO_CYC(ms) ((ms) * (`CLK_HZ / 1000))

// Shadow image width: valid, param_ok, code, arg, len, addr
`define SHADOW_W 46

`endif

/* File: hdl/replay_timer.v */
`timescale 1ns/1ps
`default_nettype none
`include "cmd_line_defs.vh"

module replay_timer #(
  parameter TICK_CYC = `CLK_HZ / `REPLAY_TICKS_PER_S
) (
  input wire clk,
  input wire rst_n,
  input wire [7:0] factor_a,
  input wire [7:0] factor_b,
  output reg expire
);
  reg [31:0] div_cnt;
  reg [15:0] tick_cnt;
  wire [15:0] interval = factor_a * factor_b;
  wire running = (factor_a != 8'h00) && (factor_b != 8'h00);
  wire tick = (div_cnt == TICK_CYC - 1);

  // Sixteenth-second enable and tick counter; zero factor holds everything cleared
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= 32'h0000_0000;
      tick_cnt <= 16'h0000;
      expire <= 1'b0;
    end else begin
      expire <= 1'b0;
      if (!running) begin
        div_cnt <= 32'h0000_0000;
        tick_cnt <= 16'h0000;
      end else begin
        div_cnt <= tick ? 32'h0000_0000 : div_cnt + 32'h0000_0001;
        if (tick) begin
          // Compare with >= so a shrunk interval expires on the next tick, not after wrap
          if (tick_cnt + 16'h0001 >= interval) begin
            tick_cnt <= 16'h0000;
            expire <= 1'b1;
          end else begin
            tick_cnt <= tick_cnt + 16'h0001;
          end
        end
      end
    end
  end
endmodule

`default_nettype wire

/* File: hdl/watchdog_timer.v */
`timescale 1ns/1ps
`default_nettype none
`include "cmd_line_defs.vh"

module watchdog_timer #(
  parameter DEF_CYC = `MS_TO_CYC(`WDT_DEFAULT_MS),
  parameter LONG_CYC = `MS_TO_CYC(`WDT_ASSOC_MS)
) (
  input wire clk,
  input wire rst_n,
  input wire kick,
  input wire off,
  input wire long_mode,
  output reg expire
);
  reg [31:0] cnt;
  wire [31:0] limit = long_mode ? LONG_CYC : DEF_CYC;

  // Count since last kick; off holds it cleared so no bite can follow a scan
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 32'h0000_0000;
      expire <= 1'b0;
    end else begin
      expire <= 1'b0;
      if (kick || off) begin
        cnt <= 32'h0000_0000;
      end else if (cnt >= limit - 1) begin
        cnt <= 32'h0000_0000;
        expire <= 1'b1;
      end else begin
        cnt <= cnt + 32'h0000_0001;
      end
    end
  end
endmodule

`default_nettype wire

/* File: hdl/cmd_line_service.v */
`timescale 1ns/1ps
`default_nettype none
`include "cmd_line_defs.vh"

module cmd_line_service #(
  parameter TICK_CYC = `CLK_HZ / `REPLAY_TICKS_PER_S,
  parameter WDT_DEF_CYC = `MS_TO_CYC(`WDT_DEFAULT_MS),
  parameter WDT_LONG_CYC = `MS_TO_CYC(`WDT_ASSOC_MS),
  parameter BOOT_WAIT_CYC = `MS_TO_CYC(`BOOT_WAIT_MS),
  parameter ERASE_LIMIT_CYC = 2 * `MS_TO_CYC(`FULL_ERASE_MS),
  parameter SECTOR_BYTES = 4096
) (
  input wire REF_CLK_I,
  input wire RST_B_I,
  // Decoded command from the line parser
  input wire CMD_VALID_I,
  input wire [3:0] CMD_CODE_I,
  input wire [7:0] CMD_ARG_I,
  input wire [7:0] CMD_LEN_I,
  input wire [23:0] CMD_ADDR_I,
  input wire CMD_PARAM_OK_I,
  input wire CMD_SHADOW_I,
  output wire CMD_READY_O,
  // Answer to the terminal
  output reg RSP_VALID_O,
  output reg RSP_OK_O,
  output reg [7:0] RSP_DATA_O,
  // Persistent memory engine
  output reg MEM_REQ_O,
  output reg [7:0] MEM_OP_O,
  output reg [7:0] MEM_LEN_O,
  output reg [23:0] MEM_ADDR_O,
  input wire MEM_DONE_I,
  input wire MEM_OK_I,
  // Network commands handled by the radio side
  output reg NET_REQ_O,
  output reg [3:0] NET_CODE_O,
  input wire NET_DONE_I,
  input wire NET_OK_I,
  input wire MAC_ERR_I,
  input wire END_DEVICE_I,
  // Profile image of the shadow buffer
  output reg PROFILE_SAVE_O,
  output wire [`SHADOW_W-1:0] SHADOW_IMAGE_O,
  input wire [`SHADOW_W-1:0] NV_SHADOW_I,
  // Bootloader, watchdog and system reset
  output reg BOOT_JUMP_O,
  input wire PROG_CONNECT_I,
  input wire WDT_KICK_I,
  output reg SYS_RST_O,
  output reg AUTO_ACTIVE_O,
  output reg RX_ON_O,
  output wire [7:0] RECOVERY_COUNT_O
);
  localparam ST_IDLE = 4'b0001;
  localparam ST_WAIT = 4'b0010;
  localparam ST_BOOT = 4'b0100;
  localparam ST_DONE = 4'b1000;

  // Saturating increment shared by both event counters
  function [3:0] sat_inc;
    input [3:0] v;
    input [3:0] max;
    begin
      sat_inc = (v >= max) ? max : v + 4'h1;
    end
  endfunction

  reg [1:0] rst_sync;
  wire rst_n = rst_sync[1];
  reg [3:0] state;
  reg [7:0] timer_a;
  reg [7:0] timer_b;
  reg [7:0] unlock;
  reg [2:0] wdt_cnt;
  reg [3:0] mac_cnt;
  reg [`SHADOW_W-1:0] shadow;
  reg replay_pend;
  reg from_shadow;
  reg wait_mem;
  reg [3:0] wait_code;
  reg [31:0] wait_cnt;
  reg prog_seen;
  wire replay_tick;
  wire wdt_bite;

  // Release the asynchronous reset through two flops
  always @(posedge REF_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end

  // A replay waits until no host command competes for the interpreter
  wire idle = (state == ST_IDLE);
  wire host_go = idle && CMD_VALID_I;
  wire replay_go = idle && !CMD_VALID_I && replay_pend && shadow[45];
  wire go = host_go || replay_go;
  assign CMD_READY_O = idle;

  // Current line: from the host or from the shadow buffer
  wire [3:0] cur_code = replay_go ? shadow[43:40] : CMD_CODE_I;
  wire [7:0] cur_arg = replay_go ? shadow[39:32] : CMD_ARG_I;
  wire [7:0] cur_len = replay_go ? shadow[31:24] : CMD_LEN_I;
  wire [23:0] cur_addr = replay_go ? shadow[23:0] : CMD_ADDR_I;
  wire cur_pok = replay_go ? shadow[44] : CMD_PARAM_OK_I;

  // Write range must not run past the end of its sector
  wire [31:0] sect_off = {8'h00, cur_addr} % SECTOR_BYTES;
  wire in_sector = (sect_off + {24'h00_0000, cur_len}) <= SECTOR_BYTES;

  // Legality of a memory-access line
  reg mem_ok;
  always @* begin
    mem_ok = 1'b0;
    case (cur_arg)
      `MEM_EE_DUMP_APP: mem_ok = 1'b1;
      `MEM_EE_DUMP_ALL: mem_ok = 1'b1;
      `MEM_EE_LINE_WR: mem_ok = cur_pok;
      `MEM_FL_READ: mem_ok = cur_pok;
      `MEM_FL_WRITE: mem_ok = cur_pok && in_sector;
      `MEM_FL_SECT_ERASE: mem_ok = cur_pok && (cur_len == `MEM_BLOCK_SIZE);
      `MEM_FL_FULL_ERASE: mem_ok = 1'b1;
      default: mem_ok = 1'b0;
    endcase
  end

  wire boot_ok = unlock[`UNLOCK_BOOT_BIT] && !RX_ON_O;
  wire is_net = (cur_code == `CMD_ASSOCIATE) || (cur_code == `CMD_NETWORK_SCAN);
  wire wait_done = wait_mem ? MEM_DONE_I : NET_DONE_I;
  wire wait_ok = wait_mem ? MEM_OK_I : NET_OK_I;
  wire erase_late = wait_mem && (MEM_OP_O == `MEM_FL_FULL_ERASE)
                    && (wait_cnt >= ERASE_LIMIT_CYC - 1);
  wire boot_late = !prog_seen && (wait_cnt >= BOOT_WAIT_CYC - 1);
  wire mac_fail = AUTO_ACTIVE_O && MAC_ERR_I;
  wire reg_wr = go && (cur_code == `CMD_REG_WRITE);
  wire reload = go && (cur_code == `CMD_PROFILE_RELOAD);
  // Watchdog count widened for the shared helper, then cut back to three bits
  wire [3:0] next_wdt = sat_inc({1'b0, wdt_cnt}, `REC_WDT_MAX);

  // Interpreter sequence
  always @(posedge REF_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      RSP_VALID_O <= 1'b0;
      RSP_OK_O <= 1'b0;
      RSP_DATA_O <= 8'h00;
      MEM_REQ_O <= 1'b0;
      MEM_OP_O <= 8'h00;
      MEM_LEN_O <= 8'h00;
      MEM_ADDR_O <= 24'h00_0000;
      NET_REQ_O <= 1'b0;
      NET_CODE_O <= 4'h0;
      PROFILE_SAVE_O <= 1'b0;
      BOOT_JUMP_O <= 1'b0;
      SYS_RST_O <= 1'b0;
      AUTO_ACTIVE_O <= 1'b0;
      RX_ON_O <= 1'b0;
      from_shadow <= 1'b0;
      wait_mem <= 1'b0;
      wait_code <= 4'h0;
      wait_cnt <= 32'h0000_0000;
      prog_seen <= 1'b0;
    end else begin
      RSP_VALID_O <= 1'b0;
      MEM_REQ_O <= 1'b0;
      NET_REQ_O <= 1'b0;
      PROFILE_SAVE_O <= 1'b0;
      SYS_RST_O <= 1'b0;
      if (wdt_bite || mac_fail) begin
        // Soft reset: sequence aborts, registers and link state stay put
        SYS_RST_O <= 1'b1;
        state <= ST_IDLE;
        AUTO_ACTIVE_O <= 1'b0;
        BOOT_JUMP_O <= 1'b0;
      end else begin
        case (state)
          ST_IDLE: begin
            if (go) begin
              from_shadow <= replay_go;
              AUTO_ACTIVE_O <= replay_go;
              RSP_DATA_O <= 8'h00;
              wait_cnt <= 32'h0000_0000;
              state <= ST_DONE;
              RSP_OK_O <= 1'b1;
              case (cur_code)
                `CMD_MEM_ACCESS: begin
                  if (mem_ok) begin
                    MEM_REQ_O <= 1'b1;
                    MEM_OP_O <= cur_arg;
                    MEM_LEN_O <= cur_len;
                    MEM_ADDR_O <= cur_addr;
                    wait_mem <= 1'b1;
                    state <= ST_WAIT;
                  end else begin
                    RSP_OK_O <= 1'b0;
                  end
                end
                `CMD_BOOT_JUMP: begin
                  if (boot_ok) begin
                    BOOT_JUMP_O <= 1'b1;
                    prog_seen <= 1'b0;
                    state <= ST_BOOT;
                  end else begin
                    RSP_OK_O <= 1'b0;
                  end
                end
                `CMD_RECEIVER_OFF: RX_ON_O <= 1'b0;
                `CMD_PROFILE_SAVE: PROFILE_SAVE_O <= 1'b1;
                `CMD_SHADOW_REPLAY: RSP_OK_O <= 1'b1;
                `CMD_PROFILE_RELOAD: RSP_OK_O <= 1'b1;
                `CMD_REG_WRITE: RSP_OK_O <= 1'b1;
                `CMD_REG_READ: begin
                  case (cur_arg)
                    `REG_TIMER_A: RSP_DATA_O <= timer_a;
                    `REG_TIMER_B: RSP_DATA_O <= timer_b;
                    `REG_UNLOCK: RSP_DATA_O <= unlock;
                    `REG_RECOVERY: RSP_DATA_O <= RECOVERY_COUNT_O;
                    default: RSP_OK_O <= 1'b0;
                  endcase
                end
                default: begin
                  if (is_net) begin
                    NET_REQ_O <= 1'b1;
                    NET_CODE_O <= cur_code;
                    wait_mem <= 1'b0;
                    wait_code <= cur_code;
                    state <= ST_WAIT;
                  end else begin
                    RSP_OK_O <= 1'b0;
                  end
                end
              endcase
            end
          end
          ST_WAIT: begin
            wait_cnt <= wait_cnt + 32'h0000_0001;
            if (wait_done || erase_late) begin
              // Full erase reports only when the engine finishes, or errors if it hangs
              RSP_OK_O <= wait_done && wait_ok;
              if (!wait_mem && wait_done && NET_OK_I && (wait_code == `CMD_ASSOCIATE)) begin
                RX_ON_O <= 1'b1;
              end
              state <= ST_DONE;
            end
          end
          ST_BOOT: begin
            // No answer here: the loader owns the port until it resets us
            if (PROG_CONNECT_I) begin
              prog_seen <= 1'b1;
            end
            if (!prog_seen) begin
              wait_cnt <= wait_cnt + 32'h0000_0001;
            end
            if (boot_late && !PROG_CONNECT_I) begin
              SYS_RST_O <= 1'b1;
              BOOT_JUMP_O <= 1'b0;
              state <= ST_IDLE;
            end
          end
          ST_DONE: begin
            RSP_VALID_O <= 1'b1;
            AUTO_ACTIVE_O <= 1'b0;
            state <= ST_IDLE;
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end

  // Registers the command set writes; reload and zero-write clear counters
  always @(posedge REF_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      timer_a <= `REG_RESET_VAL;
      timer_b <= `REG_RESET_VAL;
      unlock <= `REG_RESET_VAL;
    end else begin
      if (reg_wr && (cur_arg == `REG_TIMER_A)) begin
        timer_a <= cur_len;
      end
      if (reg_wr && (cur_arg == `REG_TIMER_B)) begin
        timer_b <= cur_len;
      end
      // Unlock lives one command only and never joins the profile image
      if (reg_wr && (cur_arg == `REG_UNLOCK)) begin
        unlock <= cur_len;
      end else if (go) begin
        unlock <= `REG_RESET_VAL;
      end
    end
  end

  // Event counters; an event in the clearing cycle still counts
  always @(posedge REF_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      wdt_cnt <= 3'h0;
      mac_cnt <= 4'h0;
    end else begin
      if (wdt_bite) begin
        wdt_cnt <= next_wdt[2:0];
      end else if (reload) begin
        wdt_cnt <= 3'h0;
      end else if (reg_wr && (cur_arg == `REG_RECOVERY)) begin
        wdt_cnt <= cur_len[`REC_WDT_MSB:`REC_WDT_LSB];
      end
      if (mac_fail) begin
        mac_cnt <= sat_inc(mac_cnt, `REC_MAC_MAX);
      end else if (reload) begin
        mac_cnt <= 4'h0;
      end else if (reg_wr && (cur_arg == `REG_RECOVERY)) begin
        mac_cnt <= cur_len[`REC_MAC_MSB:`REC_MAC_LSB];
      end
    end
  end
  assign RECOVERY_COUNT_O = {mac_cnt, 1'b0, wdt_cnt};

  // Shadow buffer: prefixed lines captured as typed, whatever their result
  always @(posedge REF_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      shadow <= {`SHADOW_W{1'b0}};
      replay_pend <= 1'b0;
    end else begin
      if (host_go && CMD_SHADOW_I) begin
        shadow <= {1'b1, CMD_PARAM_OK_I, CMD_CODE_I, CMD_ARG_I, CMD_LEN_I,
                   CMD_ADDR_I};
      end else if (reload) begin
        shadow <= NV_SHADOW_I;
      end
      // Manual replay queues the line for the next idle cycle with no host command valid
      // A request in the launch cycle wins, so no timer expiry is lost
      if ((host_go && (CMD_CODE_I == `CMD_SHADOW_REPLAY)) || replay_tick) begin
        replay_pend <= 1'b1;
      end else if (replay_go) begin
        replay_pend <= 1'b0;
      end
    end
  end
  assign SHADOW_IMAGE_O = shadow;

  replay_timer #(
    .TICK_CYC(TICK_CYC)
  ) u_replay (
    .clk(REF_CLK_I),
    .rst_n(rst_n),
    .factor_a(timer_a),
    .factor_b(timer_b),
    .expire(replay_tick)
  );

  // Scan and bootloader wait switch the dog off; end-device join stretches it
  watchdog_timer #(
    .DEF_CYC(WDT_DEF_CYC),
    .LONG_CYC(WDT_LONG_CYC)
  ) u_wdt (
    .clk(REF_CLK_I),
    .rst_n(rst_n),
    .kick(WDT_KICK_I),
    .off((state == ST_BOOT) || ((state == ST_WAIT) && !wait_mem
         && (wait_code == `CMD_NETWORK_SCAN))),
    .long_mode((state == ST_WAIT) && !wait_mem && END_DEVICE_I
               && (wait_code == `CMD_ASSOCIATE)),
    .expire(wdt_bite)
  );
endmodule

`default_nettype wire

/* File: dv/resp_model.sv */
`timescale 1ns/1ps
`default_nettype none
module resp_model (
  input wire logic clk_i,
  input wire logic req_i,
  input wire logic ok_i,
  input wire logic [7:0] delay_i,
  output var logic done_o,
  output wire logic ok_o
);
  logic busy = 1'b0;
  logic tgl = 1'b0;
  logic [7:0] cnt = 8'h00;
  initial done_o = 1'b0;
  // Counts out the chosen latency, so slow jobs such as a long erase can be staged
  always @(posedge clk_i) begin
    tgl <= !tgl;
    done_o <= 1'b0;
    if (req_i) begin
      busy <= 1'b1;
      cnt <= delay_i;
    end else if (busy) begin
      if (cnt == 8'h00) begin
        busy <= 1'b0;
        done_o <= 1'b1;
      end else begin
        cnt <= cnt - 8'h01;
      end
    end
  end
  // Status means nothing away from done; it wanders so the design cannot lean on it
  assign ok_o = done_o ? ok_i : tgl;
endmodule
`default_nettype wire

/* File: dv/cmd_line_service_sva.sv */
`timescale 1ns/1ps
`default_nettype none
`include "cmd_line_defs.vh"
module cmd_line_service_sva (
  input wire logic REF_CLK_I,
  input wire logic RST_B_I,
  input wire logic CMD_VALID_I,
  input wire logic [3:0] CMD_CODE_I,
  input wire logic [7:0] CMD_ARG_I,
  input wire logic CMD_READY_O,
  input wire logic RSP_VALID_O,
  input wire logic RSP_OK_O,
  input wire logic MEM_REQ_O,
  input wire logic [7:0] MEM_OP_O,
  input wire logic PROFILE_SAVE_O,
  input wire logic BOOT_JUMP_O,
  input wire logic PROG_CONNECT_I,
  input wire logic SYS_RST_O,
  input wire logic AUTO_ACTIVE_O,
  input wire logic RX_ON_O,
  input wire logic [7:0] RECOVERY_COUNT_O
);
  // Accepted command and its memory-access flavour
  wire logic take = CMD_VALID_I && CMD_READY_O;
  wire logic mem = take && (CMD_CODE_I == `CMD_MEM_ACCESS);
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!RST_B_I);
  take_busy_a: assert property (take |=> !CMD_READY_O)
    else $error("port still ready after a take");
  rsp_pulse_a: assert property (RSP_VALID_O |=> !RSP_VALID_O)
    else $error("answer longer than one cycle");
  reg_answer_a: assert property (
    take && CMD_CODE_I == `CMD_REG_WRITE |-> ##2 RSP_VALID_O)
    else $error("register write not answered");
  mem_req_a: assert property (
    mem && CMD_ARG_I inside {8'h01, 8'h02, 8'h07} |=> MEM_REQ_O && MEM_OP_O == $past(CMD_ARG_I))
    else $error("memory job missing or wrong");
  bad_arg_a: assert property (
    mem && (CMD_ARG_I == 8'h00 || CMD_ARG_I > 8'h07) |-> ##2 RSP_VALID_O && !RSP_OK_O)
    else $error("bad argument not refused");
  boot_rx_a: assert property ($rose(BOOT_JUMP_O) |-> !RX_ON_O)
    else $error("boot jump with receiver on");
  boot_quiet_a: assert property (BOOT_JUMP_O |-> !RSP_VALID_O)
    else $error("answer during boot wait");
  boot_timeout_a: assert property (
    BOOT_JUMP_O && !PROG_CONNECT_I |-> ##[0:60] SYS_RST_O)
    else $error("boot wait did not end in reset");
  wdt_sat_a: assert property (
    $past(RECOVERY_COUNT_O[2:0]) == 3'h7 && !$past(CMD_VALID_I) |-> RECOVERY_COUNT_O[2:0] == 3'h7)
    else $error("watchdog count left saturation");
  mac_sat_a: assert property (
    $past(RECOVERY_COUNT_O[7:4]) == 4'hF && !$past(CMD_VALID_I) |-> RECOVERY_COUNT_O[7:4] == 4'hF)
    else $error("recovery count left saturation");
  cover property ($rose(BOOT_JUMP_O));
  cover property (AUTO_ACTIVE_O ##1 SYS_RST_O);
  cover property (PROFILE_SAVE_O);
  cover property (RECOVERY_COUNT_O == 8'hF7);
endmodule
bind cmd_line_service cmd_line_service_sva u_sva (
  .REF_CLK_I(REF_CLK_I), .RST_B_I(RST_B_I), .CMD_VALID_I(CMD_VALID_I),
  .CMD_CODE_I(CMD_CODE_I), .CMD_ARG_I(CMD_ARG_I), .CMD_READY_O(CMD_READY_O),
  .RSP_VALID_O(RSP_VALID_O), .RSP_OK_O(RSP_OK_O), .MEM_REQ_O(MEM_REQ_O), .MEM_OP_O(MEM_OP_O),
  .PROFILE_SAVE_O(PROFILE_SAVE_O), .BOOT_JUMP_O(BOOT_JUMP_O), .PROG_CONNECT_I(PROG_CONNECT_I),
  .SYS_RST_O(SYS_RST_O), .AUTO_ACTIVE_O(AUTO_ACTIVE_O), .RX_ON_O(RX_ON_O),
  .RECOVERY_COUNT_O(RECOVERY_COUNT_O));
`default_nettype wire

/* File: dv/cmd_line_service_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "cmd_line_defs.vh"
module cmd_line_service_bench;
  localparam int TICK = 4;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic cv = 1'b0, pok = 1'b0, sh = 1'b0, mac = 1'b0, endv = 1'b0, kick = 1'b0, kick_en = 1'b1;
  logic prog = 1'b0, mok_in = 1'b1, nok_in = 1'b1;
  logic [3:0] code = 4'h0;
  logic [7:0] arg = 8'h00, len = 8'h00, mdly = 8'h02, ndly = 8'h02, dat, a, l;
  logic [23:0] addr = 24'h00_0000, ad;
  logic [45:0] nv = 46'h0;
  logic [63:0] rr;
  logic [2:0] kc = 3'h0;
  logic got, ok, p, e;
  wire rdy, rv, rok, mreq, mdone, mok, nreq, ndone, nok, psave, boot, srst, auto, rxon;
  wire [7:0] rdat, mop, mlen, rcnt;
  wire [3:0] ncode;
  wire [23:0] maddr;
  wire [45:0] shimg;
  int fails = 0, checks_done = 0, rst_seen = 0, i, n, s;

  // Short counts keep the run brief; expectations use the same figures
  cmd_line_service #(.TICK_CYC(TICK), .WDT_DEF_CYC(40), .WDT_LONG_CYC(160),
    .BOOT_WAIT_CYC(50), .ERASE_LIMIT_CYC(30)) u_dut (
    .REF_CLK_I(clk), .RST_B_I(rst_b), .CMD_VALID_I(cv), .CMD_CODE_I(code), .CMD_ARG_I(arg),
    .CMD_LEN_I(len), .CMD_ADDR_I(addr), .CMD_PARAM_OK_I(pok), .CMD_SHADOW_I(sh),
    .CMD_READY_O(rdy), .RSP_VALID_O(rv), .RSP_OK_O(rok), .RSP_DATA_O(rdat),
    .MEM_REQ_O(mreq), .MEM_OP_O(mop), .MEM_LEN_O(mlen), .MEM_ADDR_O(maddr),
    .MEM_DONE_I(mdone), .MEM_OK_I(mok), .NET_REQ_O(nreq), .NET_CODE_O(ncode),
    .NET_DONE_I(ndone), .NET_OK_I(nok), .MAC_ERR_I(mac), .END_DEVICE_I(endv),
    .PROFILE_SAVE_O(psave), .SHADOW_IMAGE_O(shimg), .NV_SHADOW_I(nv), .BOOT_JUMP_O(boot),
    .PROG_CONNECT_I(prog), .WDT_KICK_I(kick), .SYS_RST_O(srst), .AUTO_ACTIVE_O(auto),
    .RX_ON_O(rxon), .RECOVERY_COUNT_O(rcnt));
  resp_model u_mem (.clk_i(clk), .req_i(mreq), .ok_i(mok_in), .delay_i(mdly), .done_o(mdone),
    .ok_o(mok));
  resp_model u_net (.clk_i(clk), .req_i(nreq), .ok_i(nok_in), .delay_i(ndly), .done_o(ndone),
    .ok_o(nok));

  always #25 clk = ~clk;
  // Periodic kicks keep the watchdog quiet unless a test wants it to bite
  always @(posedge clk) begin
    #2;
    kc = kc + 3'h1;
    kick = kick_en && (kc == 3'h0);
  end
  // Soft reset requests are counted a step before the tasks look
  always @(posedge clk) begin
    #1;
    if (srst === 1'b1) rst_seen++;
  end

  task automatic stop_test;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [47:0] ex, sn);
    checks_done++;
    if (sn !== ex) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, ex, sn);
    end
  endtask
  task automatic chk_rsp(input string nm, input logic ex);
    checks_done++;
    if (got !== 1'b1 || ok !== ex) begin
      fails++;
      $display("[ERR] %s expected %b seen %b/%b", nm, ex, got, ok);
    end
  endtask
  // Hold the request through the edge that takes it, then drop it
  task automatic send(input [3:0] c, input [7:0] ar, ln, input [23:0] ads, input pk, sd);
    int k;
    for (k = 0; k < 2000 && rdy !== 1'b1; k++) begin @(posedge clk); #2; end
    code = c; arg = ar; len = ln; addr = ads; pok = pk; sh = sd; cv = 1'b1;
    @(posedge clk);
    #2 cv = 1'b0;
  endtask
  task automatic cmd(input [3:0] c, input [7:0] ar, ln, input [23:0] ads, input pk, sd);
    int k;
    send(c, ar, ln, ads, pk, sd);
    got = 1'b0; ok = 1'b0; dat = 8'h00;
    for (k = 0; k < 300 && !got; k++) begin
      if (rv === 1'b1) begin got = 1'b1; ok = rok; dat = rdat; end
      else begin @(posedge clk); #2; end
    end
  endtask
  task automatic wreg(input [7:0] r, v);
    cmd(`CMD_REG_WRITE, r, v, 24'h00_0000, 1'b1, 1'b0);
    chk_rsp("reg_write", 1'b1);
  endtask
  task automatic wait_req;
    for (n = 1; n < 500; n++) begin @(posedge clk); #2; if (mreq === 1'b1) break; end
  endtask
  task automatic wait_rst;
    s = rst_seen;
    for (n = 0; n < 100 && rst_seen == s; n++) begin @(posedge clk); #2; end
  endtask
  function automatic logic mem_exp(input [7:0] ar, ln, input [23:0] ads, input pk);
    if (ar == 8'h01 || ar == 8'h02 || ar == 8'h07) return 1'b1;
    if (ar < 8'h03 || ar > 8'h07 || !pk) return 1'b0;
    if (ar == 8'h06) return ln == `MEM_BLOCK_SIZE;
    if (ar == 8'h05) return (ads % 4096 + ln) <= 4096;
    return 1'b1;
  endfunction

  // Watchdog on the whole run, sized well past the expected length
  initial begin
    #1_000_000;
    fails++;
    stop_test;
  end
  initial begin
    void'($urandom(43727));
    rr = {$urandom(), $urandom()};
    nv = rr[45:0];
    repeat (2) @(posedge clk);
    #2 rst_b = 1'b1;
    repeat (3) @(posedge clk);
    #2 chk("count_reset", 8'h00, rcnt);
    wreg(`REG_TIMER_A, 8'h03);
    cmd(`CMD_REG_READ, `REG_TIMER_A, 8'h00, 24'h00_0000, 1'b1, 1'b0);
    chk("timer_a", 8'h03, dat);
    // Every argument once, then random mixes and the sector-edge corners
    for (i = 0; i < 40; i++) begin
      rr = {$urandom(), $urandom()};
      a = (i < 9) ? i[7:0] : {4'h0, rr[3:0] % 4'h9};
      l = rr[4] ? 8'h40 : {2'b00, rr[10:5]} + 8'h01;
      ad = rr[47:24];
      p = (i < 9) || rr[11];
      if (i == 9 || i == 10) begin
        a = 8'h05; l = 8'h20; p = 1'b1; ad = (i == 9) ? 24'h00_0FE0 : 24'h00_0FF0;
      end
      e = mem_exp(a, l, ad, p);
      cmd(`CMD_MEM_ACCESS, a, l, ad, p, 1'b0);
      chk_rsp("mem_access", e);
      if (e && (a == 8'h04 || a == 8'h05)) chk("mem_addr", ad, maddr);
      if (e && a == 8'h05) chk("mem_len", l, mlen);
    end
    mdly = 8'h3C;
    cmd(`CMD_MEM_ACCESS, 8'h07, 8'h00, 24'h00_0000, 1'b0, 1'b0);
    chk_rsp("erase_late", 1'b0);
    repeat (40) @(posedge clk);
    #2 mdly = 8'h02;
    // Engine failure must come back as an error
    mok_in = 1'b0;
    cmd(`CMD_MEM_ACCESS, 8'h02, 8'h00, 24'h00_0000, 1'b0, 1'b0);
    chk_rsp("mem_fail", 1'b0);
    mok_in = 1'b1;
    // A refused line is still captured whole
    cmd(`CMD_MEM_ACCESS, 8'h00, 8'h12, 24'h00_ABCD, 1'b1, 1'b1);
    chk_rsp("shadow_bad", 1'b0);
    chk("shadow_image", {2'b11, 4'h1, 8'h00, 8'h12, 24'h00_ABCD}, shimg);
    cmd(`CMD_PROFILE_SAVE, 8'h00, 8'h00, 24'h00_0000, 1'b0, 1'b0);
    chk_rsp("profile_save", 1'b1);
    cmd(`CMD_MEM_ACCESS, 8'h01, 8'h00, 24'h00_0000, 1'b0, 1'b1);
    chk_rsp("shadow_line", 1'b1);
    send(`CMD_SHADOW_REPLAY, 8'h00, 8'h00, 24'h00_0000, 1'b0, 1'b0);
    wait_req;
    chk("replay_op", 8'h01, mop);
    wreg(`REG_TIMER_A, 8'h02);
    wreg(`REG_TIMER_B, 8'h03);
    wait_req;
    wait_req;
    chk("timer_period", 2 * 3 * TICK, n);
    wreg(`REG_TIMER_A, 8'h00);
    wait_req;
    chk("timer_stop", 500, n);
    // MAC errors during replays, past saturation
    mdly = 8'h14;
    for (i = 1; i <= 16; i++) begin
      send(`CMD_SHADOW_REPLAY, 8'h00, 8'h00, 24'h00_0000, 1'b0, 1'b0);
      for (n = 0; n < 50 && auto !== 1'b1; n++) begin @(posedge clk); #2; end
      mac = 1'b1;
      @(posedge clk);
      #2 mac = 1'b0;
      wait_rst;
      chk("mac_count", (i > 15) ? 15 : i, rcnt[7:4]);
    end
    cmd(`CMD_REG_READ, `REG_TIMER_B, 8'h00, 24'h00_0000, 1'b1, 1'b0);
    chk("kept_reg", 8'h03, dat);
    kick_en = 1'b0;
    for (i = 1; i <= 8; i++) begin
      wait_rst;
      chk("wdt_count", (i > 7) ? 7 : i, rcnt[2:0]);
    end
    // Long network waits must not bite
    ndly = 8'h64;
    endv = 1'b1;
    s = rst_seen;
    cmd(`CMD_NETWORK_SCAN, 8'h00, 8'h00, 24'h00_0000, 1'b0, 1'b0);
    // Kicks resume late in the join, so leaving the long limit cannot bite at once
    fork
      cmd(`CMD_ASSOCIATE, 8'h00, 8'h00, 24'h00_0000, 1'b0, 1'b0);
      begin
        repeat (90) @(posedge clk);
        #2 kick_en = 1'b1;
      end
    join
    chk("no_bite", s, rst_seen);
    chk("rx_on", 1'b1, rxon);
    kick_en = 1'b1;
    wreg(`REG_UNLOCK, 8'h20);
    cmd(`CMD_BOOT_JUMP, 8'h00, 8'h00, 24'h00_0000, 1'b0, 1'b0);
    chk_rsp("boot_rx", 1'b0);
    cmd(`CMD_RECEIVER_OFF, 8'h00, 8'h00, 24'h00_0000, 1'b0, 1'b0);
    cmd(`CMD_BOOT_JUMP, 8'h00, 8'h00, 24'h00_0000, 1'b0, 1'b0);
    chk_rsp("boot_locked", 1'b0);
    wreg(`REG_UNLOCK, 8'h20);
    cmd(`CMD_REG_READ, `REG_TIMER_A, 8'h00, 24'h00_0000, 1'b1, 1'b0);
    cmd(`CMD_BOOT_JUMP, 8'h00, 8'h00, 24'h00_0000, 1'b0, 1'b0);
    chk_rsp("boot_volatile", 1'b0);
    wreg(`REG_UNLOCK, 8'h20);
    s = rst_seen;
    cmd(`CMD_BOOT_JUMP, 8'h00, 8'h00, 24'h00_0000, 1'b0, 1'b0);
    chk("boot_silent", 1'b0, got);
    chk("boot_reset", s + 1, rst_seen);
    // Counter clears by write, reload and hardware reset
    wreg(`REG_RECOVERY, 8'h35);
    chk("count_write", 8'h35, rcnt);
    cmd(`CMD_PROFILE_RELOAD, 8'h00, 8'h00, 24'h00_0000, 1'b0, 1'b0);
    chk("count_reload", 8'h00, rcnt);
    chk("reload_image", nv, shimg);
    wreg(`REG_RECOVERY, 8'h12);
    wreg(`REG_RECOVERY, 8'h00);
    chk("count_zero", 8'h00, rcnt);
    wreg(`REG_RECOVERY, 8'h71);
    // A connected programmer keeps the loader waiting; only a hardware reset ends it
    wreg(`REG_UNLOCK, 8'h20);
    prog = 1'b1;
    s = rst_seen;
    cmd(`CMD_BOOT_JUMP, 8'h00, 8'h00, 24'h00_0000, 1'b0, 1'b0);
    chk("boot_held", s, rst_seen);
    chk("boot_level", 1'b1, boot);
    rst_b = 1'b0;
    prog = 1'b0;
    @(posedge clk);
    #2 rst_b = 1'b1;
    chk("count_hw", 8'h00, rcnt);
    stop_test;
  end
endmodule
`default_nettype wire
